// ===== cscr_core_status_config_regs.sv
// Processor status and configuration registers of the core.
`timescale 1ns/1ps
`default_nettype none
`include "cscr_regs.svh"

// How it works
// R01: Status is 16 bits: I11 P10 E9 N7 Z6 F5 U3 L2 T1 C0.
// R02: Reset clears status bits 0..11 but sets local interrupt enable.
// R03: Status from before reset is copied into general register two.
// R04: Status bits 4 and 8 read zero; bits 12 to 15 reserved.
// R05: Status bits hold unless an instruction affects them.
// R06: Add or subtract sets carry on carry or borrow, else clears.
// R07: Trace enable traps after each instruction; traps, interrupts clear it. Code traps after every second traced instruction.
// R08: With a debug module present, trace bits make no trace trap.
// R09: Compare sets low when destination below source, unsigned.
// R10: Compare sets negative when destination below source, signed.
// R11: Compare sets zero when operands equal, else clears.
// R12: Only jump-to-user sets user bit; any exception clears it. Code also sets it by status load or restore.
// R13: User bit selects user stack pointer and drives a core output.
// R14: Load-processor-register refused in user mode; user stack pointer supervisor only.
// R15: Flag shows add or subtract overflow and bit test, set, clear.
// R16: Maskable interrupts need both enables; non-maskable always taken.
// R17: Enable and disable instructions set and clear only local enable.
// R18: Trace pending allows at most one trace trap per instruction.
// R19: Global enable written by load; cleared on reset, interrupt, debug trap.
// R20: Configuration bits 9,8,5,4,3,2 as named; all clear on reset.
// R21: Caches usable only when enabled; lock keeps fresh lines.
// R22: Wide dispatch selects 32-bit table entries, else 16-bit.
// R23: Short pairing uses low halves of registers twelve to fourteen.
// R24: Reserved bit writes ignored and read back zero.
module cscr_core_status_config_regs
(
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  input  wire logic              instr_done,
  input  wire cscr_pkg::cscr_alu_t alu_op,
  input  wire logic [15:0]       op_dest,
  input  wire logic [15:0]       op_src,
  input  wire logic              carry_in_use,
  input  wire logic              bit_op,
  input  wire logic              bit_result,
  input  wire logic              irq_enable_instr,
  input  wire logic              irq_disable_instr,
  input  wire logic              jump_user_instr,
  input  wire logic              load_proc_reg_instr,
  input  wire logic              lpr_sel_status,
  input  wire logic              lpr_sel_config,
  input  wire logic              lpr_sel_usp,
  input  wire logic [15:0]       lpr_data,
  input  wire logic              restore_status,
  input  wire logic [15:0]       restore_data,
  input  wire logic              trap_taken,
  input  wire logic              irq_taken,
  input  wire logic              debug_trap,
  input  wire logic              debug_present,
  input  wire logic              irq_req,
  input  wire logic              nmi_req,
  output logic [15:0]            status_out,
  output logic [15:0]            config_out,
  output logic [15:0]            gp_two_out,
  output logic                   gp_two_load,
  output logic                   user_mode_output,
  output logic                   stack_is_user,
  output logic                   trace_trap,
  output logic                   irq_accept,
  output logic                   nmi_accept,
  output logic                   lpr_refused,
  output logic                   usp_access_ok,
  output logic                   data_cache_use,
  output logic                   instr_cache_use,
  output logic                   data_cache_lock_fill,
  output logic                   instr_cache_lock_fill,
  output logic                   wide_dispatch_entries,
  output logic                   short_pairing
);
  import cscr_pkg::*;

  cscr_state_t state_reg;
  cscr_state_t state_next;

  // Carry of a 16-bit add or borrow of a subtract, with optional carry in.
  function automatic logic [16:0] arith(input logic sub, input logic [15:0] d,
                                        input logic [15:0] s, input logic ci);
    logic [16:0] r;
    r = 17'h00000;
    if (sub)
    begin
      r = {1'b0, d} - {1'b0, s} - {16'h0000, ci};
    end
    else
    begin
      r = {1'b0, d} + {1'b0, s} + {16'h0000, ci};
    end
    return r;
  endfunction

  logic [16:0] sum;
  logic        ovf;
  logic        exc;
  logic        user_now;
  logic        copy_pend_reg;

  always_comb
  begin
    state_next = state_reg;
    sum = arith(alu_op == CSCR_ALU_SUB, op_dest, op_src,
                carry_in_use & state_reg.status[`CSCR_PS_CARRY]);
    ovf = 1'b0;
    if (alu_op == CSCR_ALU_ADD)
    begin
      ovf = (op_dest[15] == op_src[15]) && (sum[15] != op_dest[15]);
    end
    else if (alu_op == CSCR_ALU_SUB)
    begin
      ovf = (op_dest[15] != op_src[15]) && (sum[15] != op_dest[15]);
    end
    exc = trap_taken | irq_taken | debug_trap;
    user_now = state_reg.status[`CSCR_PS_USER];
    // Only gp_two_load, lpr_refused and trace_trap are one-cycle pulses; gp_two_load fires once after reset.
    // The load pulse rises with the copied word, so a consumer never
    // latches a stale value.
    state_next.saved_valid = copy_pend_reg;
    state_next.lpr_refused = 1'b0;
    state_next.trace_trap = 1'b0;
    if (copy_pend_reg)
    begin
      state_next.gp_two = state_reg.saved; // see R03
    end
    if (instr_done)
    begin
      case (alu_op)
        CSCR_ALU_ADD, CSCR_ALU_SUB:
        begin
          state_next.status[`CSCR_PS_CARRY] = sum[16]; // see R06
          state_next.status[`CSCR_PS_FLAG] = ovf; // see R15
        end
        CSCR_ALU_CMP:
        begin
          state_next.status[`CSCR_PS_LOW] = op_dest < op_src; // see R09
          state_next.status[`CSCR_PS_NEG] =
            $signed(op_dest) < $signed(op_src); // see R10
          state_next.status[`CSCR_PS_ZERO] = op_dest == op_src; // see R11
        end
        default:
        begin
          state_next.status = state_next.status; // see R05
        end
      endcase
      if (bit_op)
      begin
        state_next.status[`CSCR_PS_FLAG] = bit_result; // see R15
      end
      if (irq_enable_instr)
      begin
        state_next.status[`CSCR_PS_LOCAL_IE] = 1'b1; // see R17
      end
      else if (irq_disable_instr)
      begin
        state_next.status[`CSCR_PS_LOCAL_IE] = 1'b0; // see R17
      end
      if (jump_user_instr)
      begin
        state_next.status[`CSCR_PS_USER] = 1'b1; // see R12
      end
      if (load_proc_reg_instr && user_now)
      begin
        state_next.lpr_refused = 1'b1; // see R14
      end
      else if (load_proc_reg_instr && lpr_sel_status)
      begin
        state_next.status = lpr_data & `CSCR_PS_MASK; // see R19, R24
      end
      else if (load_proc_reg_instr && lpr_sel_config)
      begin
        state_next.config_bits = lpr_data & `CSCR_CF_MASK; // see R20, R24
      end
      // A traced instruction sets the pending bit; the next one raises the trap and clears it.
      if (!debug_present && state_reg.status[`CSCR_PS_TRACE]) // see R08
      begin
        if (!state_reg.status[`CSCR_PS_TRACE_PEND])
        begin
          state_next.status[`CSCR_PS_TRACE_PEND] = 1'b1; // see R18
        end
        else
        begin
          state_next.trace_trap = 1'b1; // see R07
          state_next.status[`CSCR_PS_TRACE_PEND] = 1'b0; // see R18
        end
      end
    end
    if (restore_status)
    begin
      state_next.status = restore_data & `CSCR_PS_MASK; // see R24
    end
    // Exception entry wins over instruction updates in the same cycle.
    if (exc)
    begin
      state_next.status[`CSCR_PS_TRACE] = 1'b0; // see R07
      state_next.status[`CSCR_PS_TRACE_PEND] = 1'b0; // see R18
      state_next.status[`CSCR_PS_USER] = 1'b0; // see R12
    end
    if (irq_taken || debug_trap)
    begin
      state_next.status[`CSCR_PS_GLOBAL_IE] = 1'b0; // see R19
    end
    state_next.status = state_next.status & `CSCR_PS_MASK; // see R04
    state_next.config_bits = state_next.config_bits & `CSCR_CF_MASK;
    state_next.irq_take = irq_req &&
      state_next.status[`CSCR_PS_LOCAL_IE] &&
      state_next.status[`CSCR_PS_GLOBAL_IE]; // see R16
    state_next.nmi_take = nmi_req; // see R16
    state_next.user_mode_output = state_next.status[`CSCR_PS_USER]; // see R13
    state_next.stack_sel = {1'b0, state_next.status[`CSCR_PS_USER]};
    state_next.usp_access_ok = !state_next.status[`CSCR_PS_USER]; // see R14
    state_next.status_rd = state_next.status; // see R01
    state_next.config_rd = state_next.config_bits;
    state_next.dc_use = state_next.config_bits[`CSCR_CF_DC_EN]; // see R21
    state_next.ic_use = state_next.config_bits[`CSCR_CF_IC_EN]; // see R21
    state_next.dc_lock_fill = state_next.config_bits[`CSCR_CF_DC_EN] &&
      state_next.config_bits[`CSCR_CF_DC_LOCK]; // see R21
    state_next.ic_lock_fill = state_next.config_bits[`CSCR_CF_IC_EN] &&
      state_next.config_bits[`CSCR_CF_IC_LOCK]; // see R21
    state_next.wide_entries = state_next.config_bits[`CSCR_CF_WIDE]; // see R22
    state_next.short_pairing =
      state_next.config_bits[`CSCR_CF_SHORT]; // see R23
  end

  // The pre-reset status lives in a register outside the reset net, so it
  // survives the reset and is handed to general register two afterwards.
  cscr_word_t keep_reg;
  logic       rst_seen_reg;

  always_ff @(posedge ref_clk)
  begin
    if (rst_n)
    begin
      keep_reg <= state_reg.status; // see R03
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= '0;
      state_reg.status <= `CSCR_PS_RESET; // see R02
      state_reg.config_bits <= `CSCR_CF_RESET; // see R20
      state_reg.status_rd <= `CSCR_PS_RESET;
      state_reg.usp_access_ok <= 1'b1;
      rst_seen_reg <= 1'b1;
      copy_pend_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      rst_seen_reg <= 1'b0;
      copy_pend_reg <= rst_seen_reg;
      if (rst_seen_reg)
      begin
        state_reg.saved <= keep_reg; // see R03
      end
    end
  end

  assign status_out            = state_reg.status_rd;
  assign config_out            = state_reg.config_rd;
  assign gp_two_out            = state_reg.gp_two;
  assign gp_two_load           = state_reg.saved_valid;
  assign user_mode_output      = state_reg.user_mode_output;
  assign stack_is_user         = state_reg.stack_sel[0];
  assign trace_trap            = state_reg.trace_trap;
  assign irq_accept            = state_reg.irq_take;
  assign nmi_accept            = state_reg.nmi_take;
  assign lpr_refused           = state_reg.lpr_refused;
  assign usp_access_ok         = state_reg.usp_access_ok;
  assign data_cache_use        = state_reg.dc_use;
  assign instr_cache_use       = state_reg.ic_use;
  assign data_cache_lock_fill  = state_reg.dc_lock_fill;
  assign instr_cache_lock_fill = state_reg.ic_lock_fill;
  assign wide_dispatch_entries = state_reg.wide_entries;
  assign short_pairing         = state_reg.short_pairing;
endmodule
`default_nettype wire

// ===== cscr_regs.svh
// Bit positions, reset values and masks of the status and configuration registers.
`ifndef CSCR_REGS_SVH
`define CSCR_REGS_SVH
`define CSCR_PS_CARRY      0
`define CSCR_PS_TRACE      1
`define CSCR_PS_LOW        2
`define CSCR_PS_USER       3
`define CSCR_PS_FLAG       5
`define CSCR_PS_ZERO       6
`define CSCR_PS_NEG        7
`define CSCR_PS_LOCAL_IE   9
`define CSCR_PS_TRACE_PEND 10
`define CSCR_PS_GLOBAL_IE  11
`define CSCR_PS_MASK       16'h0eef
`define CSCR_PS_RESET      16'h0200
`define CSCR_CF_DC_EN      2
`define CSCR_CF_DC_LOCK    3
`define CSCR_CF_IC_EN      4
`define CSCR_CF_IC_LOCK    5
`define CSCR_CF_WIDE       8
`define CSCR_CF_SHORT      9
`define CSCR_CF_MASK       16'h033c
`define CSCR_CF_RESET      16'h0000
`endif

// ===== cscr_pkg.sv
// Types shared by the status and configuration register logic.
package cscr_pkg;
  typedef logic [15:0] cscr_word_t;
  typedef enum logic [1:0]
  {
    CSCR_ALU_NONE = 2'b00,
    CSCR_ALU_ADD  = 2'b01,
    CSCR_ALU_SUB  = 2'b10,
    CSCR_ALU_CMP  = 2'b11
  } cscr_alu_t;
  typedef struct packed
  {
    cscr_word_t status;
    cscr_word_t config_bits;
    logic       saved_valid;
    cscr_word_t saved;
    cscr_word_t gp_two;
    logic       user_mode_output;
    logic       trace_trap;
    logic       irq_take;
    logic       nmi_take;
    logic       lpr_refused;
    logic [1:0] stack_sel;
    cscr_word_t status_rd;
    cscr_word_t config_rd;
    logic       usp_access_ok;
    logic       dc_use;
    logic       ic_use;
    logic       dc_lock_fill;
    logic       ic_lock_fill;
    logic       wide_entries;
    logic       short_pairing;
  } cscr_state_t;
endpackage

// ===== cscr_status_props.sv
// Concurrent checks on the status and configuration register ports.
`timescale 1ns/1ps
`default_nettype none
`include "cscr_regs.svh"
module cscr_status_props
(
  input wire logic                ref_clk, rst_n, instr_done,
  input wire cscr_pkg::cscr_alu_t alu_op,
  input wire logic [15:0]         op_dest, op_src, status_out, config_out,
  input wire logic                load_proc_reg_instr, restore_status,
  input wire logic                trap_taken, irq_taken, debug_trap,
  input wire logic                debug_present, irq_req, nmi_req,
  input wire logic                user_mode_output, stack_is_user,
  input wire logic                trace_trap, irq_accept, nmi_accept,
  input wire logic                lpr_refused
);
  import cscr_pkg::*;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  reset_value_a:
    assert property ($rose(rst_n) |-> status_out == `CSCR_PS_RESET
      && config_out == `CSCR_CF_RESET) else $error("bad reset value");
  reserved_zero_a:
    assert property ((status_out & ~`CSCR_PS_MASK) == 16'h0000
      && (config_out & ~`CSCR_CF_MASK) == 16'h0000) else $error("reserved set");
  user_output_a:
    assert property (user_mode_output == status_out[`CSCR_PS_USER]
      && stack_is_user == status_out[`CSCR_PS_USER]) else $error("user out");
  // Same-cycle restore or load overwrite the whole word, so they are excluded.
  cmp_unsigned_a:
    assert property (instr_done && alu_op == CSCR_ALU_CMP && !restore_status
      && !load_proc_reg_instr |=> status_out[`CSCR_PS_ZERO] == ($past(op_dest)
      == $past(op_src)) && status_out[`CSCR_PS_LOW] == ($past(op_dest)
      < $past(op_src))) else $error("unsigned compare flags");
  cmp_signed_a:
    assert property (instr_done && alu_op == CSCR_ALU_CMP && !restore_status
      && !load_proc_reg_instr |=> status_out[`CSCR_PS_NEG] == ($signed(
      $past(op_dest)) < $signed($past(op_src)))) else $error("signed compare");
  trap_clear_a:
    assert property (trap_taken |=> !status_out[`CSCR_PS_TRACE]
      && !status_out[`CSCR_PS_USER]) else $error("trap left bits set");
  global_clear_a:
    assert property (irq_taken || debug_trap |=> !status_out[`CSCR_PS_GLOBAL_IE]
      && !status_out[`CSCR_PS_USER]) else $error("global enable kept");
  irq_gate_a:
    assert property (irq_accept |-> $past(irq_req) && status_out[
      `CSCR_PS_LOCAL_IE] && status_out[`CSCR_PS_GLOBAL_IE]) else $error("irq");
  nmi_accept_a:
    assert property (nmi_req |=> nmi_accept) else $error("nmi not accepted");
  lpr_refuse_a:
    assert property (instr_done && load_proc_reg_instr && status_out[
      `CSCR_PS_USER] |=> lpr_refused && $stable(config_out)) else $error("lpr");
  trace_once_a:
    assert property (trace_trap |-> $past(instr_done && !debug_present
      && status_out[`CSCR_PS_TRACE_PEND])) else $error("stray trace trap");
  cover property (trace_trap);
  cover property (lpr_refused);
  cover property (irq_accept);
endmodule
bind cscr_core_status_config_regs cscr_status_props u_cscr_status_props
  (.ref_clk, .rst_n, .instr_done, .alu_op, .op_dest, .op_src, .status_out,
   .config_out, .load_proc_reg_instr, .restore_status, .trap_taken,
   .irq_taken, .debug_trap, .debug_present, .irq_req, .nmi_req,
   .user_mode_output, .stack_is_user, .trace_trap, .irq_accept,
   .nmi_accept, .lpr_refused);
`default_nettype wire

// ===== cscr_exec_model.sv
// Execution-side model that issues instructions and exception pulses.
`timescale 1ns/1ps
`default_nettype none
module cscr_exec_model
(
  input  wire logic           ref_clk,
  output logic [14:0]         ctl,
  output cscr_pkg::cscr_alu_t alu_op,
  output logic [15:0]         op_dest,
  output logic [15:0]         op_src
);
  import cscr_pkg::*;
  initial
  begin
    ctl = 15'h0000;
    alu_op = CSCR_ALU_NONE;
    op_dest = 16'h0000;
    op_src = 16'h0000;
  end
  // Released operands are inverted, so a stale value is never mistaken.
  task automatic issue(input logic [14:0] c, input cscr_alu_t a,
                       input logic [15:0] d, input logic [15:0] s);
    @(posedge ref_clk);
    #1;
    ctl = c;
    alu_op = a;
    op_dest = d;
    op_src = s;
    @(posedge ref_clk);
    #1;
    ctl = 15'h0000;
    alu_op = CSCR_ALU_NONE;
    op_dest = ~d;
    op_src = ~s;
  endtask
endmodule
`default_nettype wire

// ===== core_status_config_regs_test.sv
// Self-checking bench for the status and configuration registers.
`timescale 1ns/1ps
`default_nettype none
`include "cscr_regs.svh"
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin n_errors++; \
  $display("unexpected at %0t: got %h want %h", $time, a, e); end end
module core_status_config_regs_test;
  import cscr_pkg::*;
  localparam logic [14:0] ID = 15'h4000, CIN = 15'h2000, BOP = 15'h1000,
    EI = 15'h0400, DI = 15'h0200, JU = 15'h0100, LP = 15'h0080,
    LS = 15'h0040, LC = 15'h0020, RS = 15'h0008, TRP = 15'h0004,
    IRQ = 15'h0002, DBG = 15'h0001;
  logic ref_clk, rst_n, instr_done, carry_in_use, bit_op, bit_result;
  logic irq_enable_instr, irq_disable_instr, jump_user_instr, gp_two_load;
  logic load_proc_reg_instr, lpr_sel_status, lpr_sel_config, lpr_sel_usp;
  logic restore_status, trap_taken, irq_taken, debug_trap, debug_present;
  logic irq_req, nmi_req, user_mode_output, stack_is_user, trace_trap;
  logic irq_accept, nmi_accept, lpr_refused, usp_access_ok, data_cache_use;
  logic instr_cache_use, data_cache_lock_fill, instr_cache_lock_fill;
  logic wide_dispatch_entries, short_pairing;
  logic [14:0] ctl;
  logic [15:0] op_dest, op_src, status_out, config_out, gp_two_out;
  logic [15:0] cd [4] = '{16'h0001, 16'h0002, 16'h8000, 16'h0005};
  logic [15:0] cs [4] = '{16'h0002, 16'h0001, 16'h0001, 16'h0005};
  cscr_alu_t   alu_op;
  int          n_errors, comparisons, cycles;
  wire [15:0]  lpr_data = op_src;
  wire [15:0]  restore_data = op_src;
  wire [5:0]   cfg_use = {data_cache_use, instr_cache_use, data_cache_lock_fill,
    instr_cache_lock_fill, wide_dispatch_entries, short_pairing};
  assign {instr_done, carry_in_use, bit_op, bit_result, irq_enable_instr,
    irq_disable_instr, jump_user_instr, load_proc_reg_instr, lpr_sel_status,
    lpr_sel_config, lpr_sel_usp, restore_status, trap_taken, irq_taken,
    debug_trap} = ctl;
  cscr_exec_model u_cscr_exec_model (.ref_clk, .ctl, .alu_op, .op_dest,
    .op_src);
  cscr_core_status_config_regs u_cscr_core_status_config_regs (.ref_clk,
    .rst_n, .instr_done, .alu_op, .op_dest, .op_src, .carry_in_use, .bit_op,
    .bit_result, .irq_enable_instr, .irq_disable_instr, .jump_user_instr,
    .load_proc_reg_instr, .lpr_sel_status, .lpr_sel_config, .lpr_sel_usp,
    .lpr_data, .restore_status, .restore_data, .trap_taken, .irq_taken,
    .debug_trap, .debug_present, .irq_req, .nmi_req, .status_out, .config_out,
    .gp_two_out, .gp_two_load, .user_mode_output, .stack_is_user, .trace_trap,
    .irq_accept, .nmi_accept, .lpr_refused, .usp_access_ok, .data_cache_use,
    .instr_cache_use, .data_cache_lock_fill, .instr_cache_lock_fill,
    .wide_dispatch_entries, .short_pairing);
  initial
  begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      n_errors++;
      summarize();
    end
  end
  task automatic go(input logic [14:0] c, input cscr_alu_t a,
                    input logic [15:0] d, input logic [15:0] s);
    u_cscr_exec_model.issue(c, a, d, s);
  endtask
  task automatic pulse(input logic [14:0] c);
    go(c, CSCR_ALU_NONE, 16'h0000, 16'h0000);
  endtask
  task automatic arith(input logic [14:0] c, input cscr_alu_t a,
                       input logic [15:0] d, input logic [15:0] s,
                       input logic cy, input logic f);
    go(c, a, d, s);
    `CHK(status_out[`CSCR_PS_CARRY], cy)
    `CHK(status_out[`CSCR_PS_FLAG], f)
  endtask
  // The copy of the old status shows two edges after release.
  task automatic reset_cycle();
    @(posedge ref_clk);
    #1 rst_n = 1'b0;
    repeat (16) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask
  initial
  begin
    rst_n = 1'b0;
    debug_present = 1'b0;
    irq_req = 1'b0;
    nmi_req = 1'b0;
    reset_cycle();
    `CHK(gp_two_load, 1'b1)
    `CHK(status_out, `CSCR_PS_RESET)
    `CHK(config_out, `CSCR_CF_RESET)
    `CHK(usp_access_ok, 1'b1)
    for (int i = 0; i < 4; i++)
    begin
      go(ID, CSCR_ALU_CMP, cd[i], cs[i]);
      `CHK(status_out[`CSCR_PS_LOW], cd[i] < cs[i])
      `CHK(status_out[`CSCR_PS_NEG], $signed(cd[i]) < $signed(cs[i]))
      `CHK(status_out[`CSCR_PS_ZERO], cd[i] == cs[i])
    end
    `CHK(status_out[`CSCR_PS_LOCAL_IE], 1'b1)
    arith(ID, CSCR_ALU_ADD, 16'hffff, 16'h0001, 1'b1, 1'b0);
    arith(ID | CIN, CSCR_ALU_ADD, 16'hffff, 16'h0000, 1'b1, 1'b0);
    arith(ID, CSCR_ALU_ADD, 16'h7fff, 16'h0001, 1'b0, 1'b1);
    arith(ID, CSCR_ALU_SUB, 16'h0000, 16'h0001, 1'b1, 1'b0);
    arith(ID, CSCR_ALU_SUB, 16'h8000, 16'h0001, 1'b0, 1'b1);
    pulse(ID | BOP);
    `CHK(status_out[`CSCR_PS_FLAG], 1'b0)
    $display("test flags done");
    go(ID | LP | LS, CSCR_ALU_NONE, 16'h0000, 16'h0a00);
    `CHK(status_out, 16'h0a00)
    irq_req = 1'b1;
    @(posedge ref_clk);
    #1;
    `CHK(irq_accept, 1'b1)
    pulse(ID | DI);
    `CHK(status_out, 16'h0800)
    `CHK(irq_accept, 1'b0)
    nmi_req = 1'b1;
    @(posedge ref_clk);
    #1;
    `CHK(nmi_accept, 1'b1)
    nmi_req = 1'b0;
    pulse(ID | EI);
    `CHK(status_out, 16'h0a00)
    pulse(DBG);
    `CHK({status_out[`CSCR_PS_GLOBAL_IE], irq_accept}, 2'b00)
    irq_req = 1'b0;
    $display("test interrupts done");
    pulse(ID | JU);
    `CHK({user_mode_output, stack_is_user, usp_access_ok}, 3'b110)
    go(ID | LP | LC, CSCR_ALU_NONE, 16'h0000, 16'hffff);
    `CHK({lpr_refused, config_out}, 17'h10000)
    pulse(IRQ);
    `CHK(user_mode_output, 1'b0)
    go(ID | LP | LC, CSCR_ALU_NONE, 16'h0000, 16'hffff);
    `CHK(config_out, `CSCR_CF_MASK)
    `CHK(cfg_use, 6'h3f)
    go(ID | LP | LC, CSCR_ALU_NONE, 16'h0000, 16'hfcc3);
    `CHK({config_out, cfg_use}, 22'h000000)
    go(ID | LP | LS, CSCR_ALU_NONE, 16'h0000, 16'hfff7);
    `CHK(status_out, 16'h0ee7)
    pulse(TRP);
    `CHK(status_out[`CSCR_PS_TRACE], 1'b0)
    $display("test modes done");
    go(ID | LP | LS, CSCR_ALU_NONE, 16'h0000, 16'h0002);
    pulse(ID);
    `CHK({trace_trap, status_out[`CSCR_PS_TRACE_PEND]}, 2'b01)
    pulse(ID);
    `CHK({trace_trap, status_out[`CSCR_PS_TRACE_PEND]}, 2'b10)
    debug_present = 1'b1;
    pulse(ID);
    pulse(ID);
    `CHK(trace_trap, 1'b0)
    debug_present = 1'b0;
    go(RS, CSCR_ALU_NONE, 16'h0000, 16'h0a41);
    `CHK(status_out, 16'h0a41)
    reset_cycle();
    `CHK(gp_two_out, 16'h0a41)
    `CHK(status_out, `CSCR_PS_RESET)
    $display("test trace and reset done");
    summarize();
  end
endmodule
`default_nettype wire
